/* File: cebld_builder.sv */
// Completion record builder: packs and posts one record per finished command
// Behaviour
// - Queue number goes to dword 2 high half
// - Head snapshot taken at record creation
// - Head index tells host consumed slots
// - Phase inverted on each ring pass
// - Command tag echoed in dword 3 low
// - Status word in dword 3 bits 31:17
// - Success reports all-zero status word
// - Multiple failures: caller picks one code
// - Retry hint set when retry futile
// - Retry hint cleared on recovery abort
// - Retry hint cleared when type, code zero
// - More-info flag at status bit 30
// - Status type at bits 27:25
// - Status code at bits 24:17
// - Fabric variant reserves queue number, phase
// - Phase written only in last write
// - Record is four dwords, dword 1 reserved
// - Status type encodings generic to vendor
`timescale 1ns/10ps
module cebld_builder
  import cebld_pkg::*;
#(
  parameter int SLOT_BITS = 16
)
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic controller_enable_bit_i,
  input wire logic fabric_mode_i,
  input wire logic [SLOT_BITS-1:0] ring_last_slot_i,
  input wire logic done_valid_i,
  output logic done_ready_o,
  input wire logic [15:0] source_queue_number_i,
  input wire logic [15:0] head_index_snapshot_i,
  input wire logic [15:0] command_tag_i,
  input wire logic [31:0] specific_dword_i,
  input wire logic success_i,
  input wire logic retry_hint_flag_i,
  input wire logic more_info_i,
  input wire logic tlr_abort_i,
  input wire logic [2:0] status_type_field_i,
  input wire logic [7:0] status_code_field_i,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [SLOT_BITS-1:0] wr_slot_o,
  output logic [1:0] wr_dword_o,
  output logic [31:0] wr_data_o,
  output logic wr_last_o,
  output logic phase_o,
  output logic [SLOT_BITS-1:0] tail_o
);
  ////////////////////////////////////////////////////////////////////////////
  // State
  cebld_state_type state_reg, state_next;
  logic [1:0] dw_reg, dw_next;
  logic [SLOT_BITS-1:0] tail_reg, tail_next;
  logic phase_reg, phase_next;
  logic [31:0] dw0_reg, dw0_next;
  logic [31:0] dw2_reg, dw2_next;
  logic [31:0] dw3_reg, dw3_next;
  logic [31:0] data_reg, data_next;
  logic en_q_reg;
  logic [14:0] status_word;
  logic [2:0] type_in;
  logic [7:0] code_in;
  logic accept;
  logic beat_done;

  // Success forces all-zero type and code
  assign type_in = success_i ? CEBLD_TYPE_GENERIC : status_type_field_i;
  assign code_in = success_i ? CEBLD_CODE_SUCCESS : status_code_field_i;

  cebld_status_pack u_pack (
    .retry_hint_flag_i(retry_hint_flag_i),
    .more_info_i(more_info_i && !success_i), // Success leaves the whole status word zero
    .tlr_abort_i(tlr_abort_i),
    .status_type_field_i(type_in),
    .status_code_field_i(code_in),
    .status_word_o(status_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes
  assign done_ready_o = (state_reg == CEBLD_IDLE) && controller_enable_bit_i;
  assign accept = done_valid_i && done_ready_o;
  assign wr_valid_o = (state_reg == CEBLD_WRITE);
  assign beat_done = wr_valid_o && wr_ready_i;
  assign wr_slot_o = tail_reg;
  assign wr_dword_o = dw_reg;
  assign wr_data_o = data_reg;
  assign wr_last_o = wr_valid_o && (dw_reg == 2'(CEBLD_RECORD_DWORDS - 1));
  assign phase_o = phase_reg;
  assign tail_o = tail_reg;

  // Next-state: capture on accept, then write dwords 0..3
  always_comb
  begin
    state_next = state_reg;
    dw_next = dw_reg;
    tail_next = tail_reg;
    phase_next = phase_reg;
    dw0_next = dw0_reg;
    dw2_next = dw2_reg;
    dw3_next = dw3_reg;
    data_next = data_reg;
    if (controller_enable_bit_i && !en_q_reg)
    begin
      tail_next = '0;
      phase_next = CEBLD_PHASE_RESET;
    end
    unique case (state_reg)
      CEBLD_IDLE:
      begin
        if (accept)
        begin
          // Snapshot at creation; later head moves do not alter it
          dw0_next = specific_dword_i;
          dw2_next = {fabric_mode_i ? 16'h0000 : source_queue_number_i,
            head_index_snapshot_i};
          dw3_next = {status_word, fabric_mode_i ? 1'b0 : phase_reg,
            command_tag_i};
          data_next = specific_dword_i;
          dw_next = 2'h0;
          state_next = CEBLD_WRITE;
        end
      end
      CEBLD_WRITE:
      begin
        if (beat_done)
        begin
          dw_next = dw_reg + 2'h1;
          unique case (dw_reg)
            2'h0: data_next = 32'h0000_0000;
            2'h1: data_next = dw2_reg;
            2'h2: data_next = dw3_reg;
            2'h3: data_next = data_reg;
          endcase
          if (dw_reg == 2'(CEBLD_RECORD_DWORDS - 1))
          begin
            state_next = CEBLD_IDLE;
            if (tail_reg == ring_last_slot_i)
            begin
              tail_next = '0;
              phase_next = !phase_reg;
            end
            else
            begin
              tail_next = tail_reg + SLOT_BITS'(1);
            end
          end
        end
      end
      default:
      begin
        state_next = CEBLD_IDLE; // Unused state codes fall back to idle
      end
    endcase
    if (!controller_enable_bit_i)
    begin
      state_next = CEBLD_IDLE;
    end
  end

  // Registers
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= CEBLD_IDLE;
      dw_reg <= 2'h0;
      tail_reg <= '0;
      phase_reg <= CEBLD_PHASE_RESET;
      dw0_reg <= 32'h0000_0000;
      dw2_reg <= 32'h0000_0000;
      dw3_reg <= 32'h0000_0000;
      data_reg <= 32'h0000_0000;
      en_q_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      dw_reg <= dw_next;
      tail_reg <= tail_next;
      phase_reg <= phase_next;
      dw0_reg <= dw0_next;
      dw2_reg <= dw2_next;
      dw3_reg <= dw3_next;
      data_reg <= data_next;
      en_q_reg <= controller_enable_bit_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence seq_last_beat;
    wr_valid_o && wr_ready_i && wr_last_o;
  endsequence

  sequence seq_wrap;
    seq_last_beat ##0 (tail_reg == ring_last_slot_i) ##0 controller_enable_bit_i;
  endsequence

  AST_PHASE_TOGGLE: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    seq_wrap |=> (phase_reg != $past(phase_reg)) && (tail_reg == '0))
    else $error("phase did not toggle on ring wrap");

  AST_PHASE_HOLD: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (controller_enable_bit_i && en_q_reg && !(wr_last_o && wr_ready_i && (tail_reg == ring_last_slot_i)))
    |=> $stable(phase_reg))
    else $error("phase changed without wrap");

  AST_PHASE_ENABLE: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (controller_enable_bit_i && !en_q_reg) |=> phase_reg && (tail_reg == '0))
    else $error("phase not one after enable");

  AST_QNUM_FIELD: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (accept && !fabric_mode_i) |=> (dw2_reg[31:16] == $past(source_queue_number_i)))
    else $error("queue number misplaced");

  AST_HEAD_FIELD: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    accept |=> (dw2_reg[15:0] == $past(head_index_snapshot_i)) ##1 $stable(dw2_reg[15:0]))
    else $error("head snapshot not held");

  AST_TAG_FIELD: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    accept |=> (dw3_reg[15:0] == $past(command_tag_i)))
    else $error("command tag not echoed");

  AST_SUCCESS_ZERO: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (accept && success_i) |=> (dw3_reg[31:17] == 15'h0000))
    else $error("success status not zero");

  AST_RETRY_CLEAR: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (accept && tlr_abort_i) |=> !dw3_reg[CEBLD_RETRY_BIT])
    else $error("retry hint set on recovery abort");

  AST_FABRIC_RSVD: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (accept && fabric_mode_i) |=> (dw2_reg[31:16] == 16'h0000) && !dw3_reg[CEBLD_PHASE_BIT])
    else $error("reserved fields filled in fabric mode");

  AST_LAST_IS_DW3: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    seq_last_beat |-> (wr_data_o == dw3_reg) && (dw_reg == 2'h3))
    else $error("phase dword not written last");
endmodule

/* File: cebld_host.sv */
// Host memory model: takes record beats and collects one record
`timescale 1ns/10ps
module cebld_host
  import cebld_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic slow_i,
  input wire logic wr_valid_i,
  input wire logic [1:0] wr_dword_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_last_i,
  output logic wr_ready_o,
  output logic rec_done_o,
  output logic [127:0] rec_o,
  output logic order_ok_o
);
  logic [1:0] beat_reg;
  logic tog_reg;
  ////////////////////////////////////////////////////////////
  // Slow host takes a beat every other cycle
  assign wr_ready_o = !slow_i || tog_reg;
  // Beat capture and order check
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tog_reg <= 1'b0;
      beat_reg <= 2'h0;
      rec_done_o <= 1'b0;
      rec_o <= '0; // Slot starts with phase clear
      order_ok_o <= 1'b1;
    end
    else
    begin
      tog_reg <= !tog_reg;
      rec_done_o <= wr_valid_i && wr_ready_o && wr_last_i;
      if (!wr_valid_i)
        beat_reg <= 2'h0;
      else if (wr_ready_o)
      begin
        beat_reg <= beat_reg + 2'h1;
        rec_o[wr_dword_i*32 +: 32] <= wr_data_i;
        if (wr_dword_i != beat_reg || wr_last_i != (beat_reg == 2'h3))
          order_ok_o <= 1'b0; // Dwords 0..3, last is 3
      end
    end
  end
endmodule

/* File: cebld_pkg.sv */
// Package: field layout, encodings and sizes of the completion record builder
package cebld_pkg;
  localparam int CEBLD_DW_WIDTH = 32;
  localparam int CEBLD_RECORD_BYTES = 16;
  localparam int CEBLD_RECORD_DWORDS = CEBLD_RECORD_BYTES / 4;
  // Dword 2 fields
  localparam int CEBLD_QNUM_LSB = 16;
  localparam int CEBLD_HEAD_LSB = 0;
  // Dword 3 fields
  localparam int CEBLD_TAG_LSB = 0;
  localparam int CEBLD_PHASE_BIT = 16;
  localparam int CEBLD_STATUS_LSB = 17;
  localparam int CEBLD_CODE_LSB = 17;
  localparam int CEBLD_TYPE_LSB = 25;
  localparam int CEBLD_RSVD_LSB = 28;
  localparam int CEBLD_MORE_BIT = 30;
  localparam int CEBLD_RETRY_BIT = 31;
  // Status type encodings
  localparam logic [2:0] CEBLD_TYPE_GENERIC = 3'h0;
  localparam logic [2:0] CEBLD_TYPE_CMD_SPECIFIC = 3'h1;
  localparam logic [2:0] CEBLD_TYPE_MEDIA = 3'h2;
  localparam logic [2:0] CEBLD_TYPE_VENDOR = 3'h7;
  localparam logic [7:0] CEBLD_CODE_SUCCESS = 8'h00;
  // Reset value and reserved-field value
  localparam logic CEBLD_PHASE_RESET = 1'b1;
  localparam logic [1:0] CEBLD_RSVD_VALUE = 2'h0;
  // Record write sequence states
  typedef enum logic [1:0] {CEBLD_IDLE, CEBLD_WRITE} cebld_state_type;
endpackage

/* File: cebld_status_pack.sv */
// Status word packer for one completion record
`timescale 1ns/10ps
module cebld_status_pack
  import cebld_pkg::*;
(
  input wire logic retry_hint_flag_i,
  input wire logic more_info_i,
  input wire logic tlr_abort_i,
  input wire logic [2:0] status_type_field_i,
  input wire logic [7:0] status_code_field_i,
  output logic [14:0] status_word_o
);
  logic retry_eff;
  logic all_zero;

  // Retry hint forced clear on recovery abort or clean status
  always_comb
  begin
    all_zero = (status_type_field_i == CEBLD_TYPE_GENERIC) && (status_code_field_i == CEBLD_CODE_SUCCESS);
    retry_eff = retry_hint_flag_i && !tlr_abort_i && !all_zero;
    // Pack fields, reserved bits driven zero
    status_word_o = {retry_eff, more_info_i, CEBLD_RSVD_VALUE, status_type_field_i,
      status_code_field_i};
  end
endmodule

/* File: testbench.sv */
// Testbench: random completions through the builder against a model
`timescale 1ns/10ps
module testbench;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic en = 1'b0, fab = 1'b0, dv = 1'b0, slow = 1'b0;
  logic succ = 1'b0, rt = 1'b0, mi = 1'b0, tlr = 1'b0;
  logic rdy, wv, wrdy, wl, ph, rdone, ok;
  logic [2:0] tl, slot;
  logic [1:0] wdw;
  logic [31:0] wd, sd = 32'h0, seed = 32'h2f12;
  logic [15:0] qn = 16'h0, hd = 16'h0, tag = 16'h0;
  logic [2:0] ty = 3'h0;
  logic [7:0] cd = 8'h00;
  logic [127:0] rec;
  int failures = 0, n_compared = 0, tail_m = 0, phase_m = 1;
  ////////////////////////////////////////////////////////////
  // Design with a four-slot ring, and the host model
  cebld_builder #(.SLOT_BITS(3)) cebld_builder_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .controller_enable_bit_i(en), .fabric_mode_i(fab), .ring_last_slot_i(3'h3),
    .done_valid_i(dv), .done_ready_o(rdy), .source_queue_number_i(qn), .head_index_snapshot_i(hd),
    .command_tag_i(tag), .specific_dword_i(sd), .success_i(succ), .retry_hint_flag_i(rt),
    .more_info_i(mi), .tlr_abort_i(tlr), .status_type_field_i(ty), .status_code_field_i(cd),
    .wr_valid_o(wv), .wr_ready_i(wrdy), .wr_slot_o(slot), .wr_dword_o(wdw), .wr_data_o(wd),
    .wr_last_o(wl), .phase_o(ph), .tail_o(tl));
  cebld_host cebld_host_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .slow_i(slow),
    .wr_valid_i(wv), .wr_dword_i(wdw), .wr_data_i(wd), .wr_last_i(wl), .wr_ready_o(wrdy),
    .rec_done_o(rdone), .rec_o(rec), .order_ok_o(ok));
  always #5 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction
  task automatic step();
    @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // New random completion fields
  task automatic rnd();
    logic [2:0] types [4];
    types = '{cebld_pkg::CEBLD_TYPE_GENERIC, cebld_pkg::CEBLD_TYPE_CMD_SPECIFIC,
      cebld_pkg::CEBLD_TYPE_MEDIA, cebld_pkg::CEBLD_TYPE_VENDOR};
    seed = lfsr(seed);
    qn = seed[15:0];
    hd = seed[31:16];
    seed = lfsr(seed);
    sd = seed;
    seed = lfsr(seed);
    ty = types[seed[1:0]];
    cd = seed[2] ? 8'h00 : seed[10:3];
    succ = seed[11] & seed[12];
    rt = seed[13];
    mi = seed[14];
    tlr = seed[15] & seed[16];
  endtask
  // One completion, optionally aborted by dropping enable mid-record
  task automatic send(input logic abort);
    logic [14:0] st;
    logic [127:0] e;
    int n;
    seed = lfsr(seed);
    fab = seed[3] & seed[7];
    slow = seed[5];
    st = succ ? 15'h0 : {rt & ~tlr & (ty != 3'h0 || cd != 8'h00), mi, 2'h0, ty, cd};
    e = {st, ~fab & phase_m[0], tag, fab ? 16'h0 : qn, hd, 32'h0, sd};
    dv = 1'b1;
    for (n = 0; rdy !== 1'b1 && n < 50; n++)
      step();
    chk("ready_wait", 1'b1, rdy);
    step();
    dv = 1'b0;
    tag = tag + 16'h1; // Unique tags, far below the limit
    rnd();
    chk("done_ready", 1'b0, rdy);
    chk("slot", tail_m, slot);
    if (abort)
    begin
      en = 1'b0;
      step();
      chk("abort_valid", 1'b0, wv);
      en = 1'b1;
      tail_m = 0;
      phase_m = 1;
      step();
      step();
    end
    else
    begin
      for (n = 0; rdone !== 1'b1 && n < 50; n++)
        step();
      chk("record_done", 1'b1, rdone);
      chk("record", e, rec);
      chk("order", 1'b1, ok);
      tail_m = (tail_m == 3) ? 0 : tail_m + 1;
      if (tail_m == 0)
        phase_m = 1 - phase_m;
    end
    chk("tail", tail_m, tl);
    chk("phase", phase_m, ph);
  endtask
  task automatic results();
    if (failures == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rnd();
    repeat (10) @(posedge mclk_i);
    #1;
    reset_n_i = 1'b1;
    en = 1'b1;
    step();
    chk("start_phase", 1'b1, ph);
    for (int i = 0; i < 40; i++)
      send(i == 17);
    results();
  end
  // Watchdog
  initial
  begin
    #40000;
    failures++;
    results();
  end
endmodule
